// file: swp_ctrl.sv
// Secure write-protect control: hidden configuration area and command gating
`timescale 1ns/1ns
`default_nettype none
`include "swp_defines.svh"
// Notes on behaviour
// - Secure mode: protect bytes change only when permitted
// - Permit mask is set only by authenticated frame
// - Info byte: bit1 mode, bit0 always one
// - Mode bit0 selects legacy or secure
// - Mode changes keep existing protections untouched
// - Legacy mode: CMD27 and CMD6 update protection
// - Mode and permit bytes reset to zero
// - Blocked CMD27 generic error, CMD6 switch error
// - Blocked forced erase fails, stays locked, flags
// - Blocked CMD28 and CMD29 give generic error
// - Boot protect byte survives resets when blocked
// - Accepted forced erase clears password and unlocks
// - Forced erase fails if hard groups exist
// - Forced erase on unlocked device fails
// - CMD28 type from user protect bits 2,0
// - Permit opens temporary and boot power-on protections
// - Power-on and permanent groups stay closed
// - Clearing permit or resets re-protects areas
// - Request types 1..7, 6 write, 7 read
// - Responses tagged with matching response code
// - Config area: mode byte 1, permit byte 2
module swp_ctrl import swp_pkg::*; #(
	parameter int NG = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic link_valid,
	input wire swp_frame_s link_frame,
	input wire logic hw_reset_n,
	output var swp_resp_s resp,
	output logic [7:0] protect_capability_info,
	output logic [7:0] user_wp,
	output logic [7:0] boot_wp,
	output logic [1:0] csd_wp,
	output logic [NG-1:0] group_writable,
	output logic boot_writable,
	output logic locked,
	output logic erase_all
);
	// Whole state of the block
	typedef struct packed {
		swp_state_e state;
		logic lclk_d; // Previous synced link clock
		swp_frame_s req; // Frame being executed
		logic [7:0] mode; // protect_mode_select
		logic [7:0] permit; // protect_update_permit
		logic [7:0] user_wp;
		logic [7:0] boot_wp;
		logic [1:0] csd_wp; // Temporary and permanent protect bits
		logic locked;
		logic [3:0] lock_password_length; // lock_password_length
		logic [15:0] last_rsp; // For result read
		logic [7:0] last_res;
		swp_resp_s resp;
		logic [7:0] info; // protect_capability_info
		logic [NG-1:0] gw;
		logic boot_wr;
		logic erase_all;
	} swp_top_s;
	swp_top_s st_reg, st_next;

	swp_link_s lk; // Synchronised link pins
	swp_wp_e [NG-1:0] gt_types;
	logic gt_hard;
	logic gt_set, gt_clr, gt_wipe;
	swp_wp_e gt_type;
	logic [NG-1:0] gw_w;
	logic [NG-1:0] hard_vec; // Groups holding a power-on or permanent type
	logic take; // Link rising edge with a frame
	logic upd_ok; // Protection fields may change
	logic perm_active; // Temporary areas opened
	logic force_erase;

	// Protection-related extended register index
	function automatic logic swp_is_wp_index(input logic [7:0] a);
		swp_is_wp_index = (a == `SWP_USER_WP_INDEX) || (a == `SWP_BOOT_WP_INDEX)
			|| (a == `SWP_BOOT_STAT_INDEX);
	endfunction : swp_is_wp_index

	// Read decode of the hidden configuration area
	function automatic logic [7:0] swp_cfg_read(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] p);
		case (a)
			`SWP_ADC_MODE_ADDR: swp_cfg_read = m;
			`SWP_ADC_PERMIT_ADDR: swp_cfg_read = p;
			default: swp_cfg_read = 8'h00; // Reserved bytes read zero
		endcase
	endfunction : swp_cfg_read

	// All link pins share one synchroniser so they stay aligned
	swp_sync #(.W($bits(swp_link_s))) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.d({link_clk, link_valid, hw_reset_n, link_frame}),
		.q(lk)
	);

	// Group protection store
	swp_group_table #(.NG(NG)) u_groups (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.set_en(gt_set),
		.clr_en(gt_clr),
		.wipe(gt_wipe),
		.idx(st_reg.req.group),
		.set_type(gt_type),
		.types(gt_types),
		.hard_any(gt_hard)
	);

	// Legacy mode always permits; secure mode follows the mask
	assign upd_ok = !st_reg.mode[`SWP_EN_BIT] || st_reg.permit[`SWP_EN_BIT];
	assign perm_active = st_reg.mode[`SWP_EN_BIT] && st_reg.permit[`SWP_EN_BIT];
	assign take = lk.clk && !st_reg.lclk_d && lk.valid && (st_reg.state == SWP_IDLE);
	assign force_erase = st_reg.req.data[`SWP_LK_ERASE_BIT];

	// Writability per group; hard types never open
	genvar g;
	generate
		for (g = 0; g < NG; g++) begin : g_wr
			assign gw_w[g] = (gt_types[g] == SWP_WP_NONE)
				|| ((gt_types[g] == SWP_WP_TEMP) && perm_active);
			assign hard_vec[g] = (gt_types[g] == SWP_WP_PWR) || (gt_types[g] == SWP_WP_PERM);
		end
	endgenerate

	// Sequencer and command execution
	always_comb begin
		st_next = st_reg;
		st_next.lclk_d = lk.clk;
		st_next.resp.valid = 1'b0;
		st_next.erase_all = 1'b0;
		gt_set = 1'b0;
		gt_clr = 1'b0;
		gt_wipe = 1'b0;
		gt_type = SWP_WP_TEMP;
		case (st_reg.state)
			SWP_IDLE: begin
				// Frames arriving while busy are dropped
				if (take) begin
					st_next.req = lk.frame;
					st_next.state = SWP_EXEC;
				end
			end
			SWP_EXEC: begin
				st_next.state = SWP_RESP;
				st_next.resp = '0;
				st_next.resp.valid = 1'b1;
				if (st_reg.req.rpmb) begin
					st_next.resp.rsp_type = {st_reg.req.req_type[7:0], 8'h00};
					case (st_reg.req.req_type)
						`SWP_REQ_CFG_WR: begin
							// Failed checks change nothing but the result
							if (!st_reg.req.mac_ok) begin
								st_next.resp.result = `SWP_RES_AUTH_FAIL;
							end else if (!st_reg.req.cnt_ok) begin
								st_next.resp.result = `SWP_RES_CNT_FAIL;
							end else if (st_reg.req.addr == `SWP_ADC_MODE_ADDR) begin
								// Groups and boot protection are untouched here
								st_next.mode = {7'h00, st_reg.req.data[`SWP_EN_BIT]};
							end else if (st_reg.req.addr == `SWP_ADC_PERMIT_ADDR) begin
								// Only path that sets the mask
								st_next.permit = {7'h00, st_reg.req.data[`SWP_EN_BIT]};
							end
							st_next.last_rsp = `SWP_RSP_CFG_WR;
							st_next.last_res = st_next.resp.result;
						end
						`SWP_REQ_CFG_RD: begin
							st_next.resp.data = swp_cfg_read(st_reg.req.addr, st_reg.mode,
								st_reg.permit);
						end
						`SWP_REQ_RESULT: begin
							st_next.resp.rsp_type = st_reg.last_rsp;
							st_next.resp.result = st_reg.last_res;
						end
						default: begin
							// Key and data frames are served elsewhere
							if ((st_reg.req.req_type < `SWP_REQ_FIRST)
								|| (st_reg.req.req_type > `SWP_REQ_CFG_RD)) begin
								st_next.resp.result = `SWP_RES_GEN_FAIL;
							end
						end
					endcase
				end else begin
					case (st_reg.req.cmd)
						`SWP_CMD_GO_IDLE: begin
							// Soft reset closes temporary openings
							st_next.permit = `SWP_PERMIT_RESET;
						end
						`SWP_CMD_SWITCH: begin
							if (swp_is_wp_index(st_reg.req.addr)) begin
								if (!upd_ok) begin
									st_next.resp.switch_err = 1'b1;
								end else if (st_reg.req.addr == `SWP_USER_WP_INDEX) begin
									st_next.user_wp = st_reg.req.data;
								end else if (st_reg.req.addr == `SWP_BOOT_WP_INDEX) begin
									st_next.boot_wp = st_reg.req.data;
								end
							end
						end
						`SWP_CMD_PROG_CSD: begin
							if (!upd_ok) begin
								st_next.resp.generic_err = 1'b1;
							end else begin
								st_next.csd_wp = st_reg.req.data[1:0];
							end
						end
						`SWP_CMD_SET_WP: begin
							if (!upd_ok) begin
								st_next.resp.generic_err = 1'b1;
							end else begin
								gt_set = 1'b1;
								if (st_reg.user_wp[`SWP_UWP_PERM_BIT]) begin
									gt_type = SWP_WP_PERM;
								end else if (st_reg.user_wp[`SWP_UWP_PWR_BIT]) begin
									gt_type = SWP_WP_PWR;
								end
							end
						end
						`SWP_CMD_CLR_WP: begin
							if (!upd_ok) begin
								st_next.resp.generic_err = 1'b1;
							end else begin
								gt_clr = 1'b1;
							end
						end
						`SWP_CMD_LOCK: begin
							if (force_erase) begin
								// Any failure leaves lock state as it was
								if (!upd_ok || !st_reg.locked || gt_hard) begin
									st_next.resp.lock_fail = 1'b1;
								end else begin
									gt_wipe = 1'b1;
									st_next.lock_password_length = 4'h0;
									st_next.locked = 1'b0;
									st_next.erase_all = 1'b1;
								end
							end else begin
								st_next.locked = st_reg.req.data[`SWP_LK_LOCK_BIT];
								if (st_reg.req.data[`SWP_LK_LOCK_BIT]) begin
									st_next.lock_password_length = st_reg.req.addr[3:0];
								end
							end
						end
						default: begin
							// Other commands do not touch protection
						end
					endcase
				end
			end
			SWP_RESP: begin
				st_next.state = SWP_IDLE;
			end
			default: begin
				st_next.state = SWP_IDLE;
			end
		endcase
		// Hardware reset pin closes temporary openings; boot byte is kept
		if (!lk.hw_reset_n) begin
			st_next.permit = `SWP_PERMIT_RESET;
		end
		st_next.info = 8'h00;
		st_next.info[`SWP_INFO_EN_BIT] = st_reg.mode[`SWP_EN_BIT];
		st_next.info[`SWP_INFO_CAP_BIT] = 1'b1;
		st_next.gw = gw_w;
		st_next.boot_wr = !(st_reg.boot_wp[`SWP_BWP_PWR_BIT] || st_reg.boot_wp[`SWP_BWP_PERM_BIT])
			|| (perm_active && !st_reg.boot_wp[`SWP_BWP_PERM_BIT]);
	end

	// Register the state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.mode <= `SWP_MODE_RESET;
			st_reg.permit <= `SWP_PERMIT_RESET;
			st_reg.info <= `SWP_INFO_RESET;
			st_reg.gw <= '1;
			st_reg.boot_wr <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state register
	assign resp = st_reg.resp;
	assign protect_capability_info = st_reg.info;
	assign user_wp = st_reg.user_wp;
	assign boot_wp = st_reg.boot_wp;
	assign csd_wp = st_reg.csd_wp;
	assign group_writable = st_reg.gw;
	assign boot_writable = st_reg.boot_wr;
	assign locked = st_reg.locked;
	assign erase_all = st_reg.erase_all;

	// Checks on the block's own behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic ex_cmd; // Executing a plain command
	logic ex_fe; // Executing a forced erase
	logic permit_may_change;
	assign ex_cmd = (st_reg.state == SWP_EXEC) && !st_reg.req.rpmb;
	assign ex_fe = ex_cmd && (st_reg.req.cmd == `SWP_CMD_LOCK) && force_erase;
	assign permit_may_change = !lk.hw_reset_n || ((st_reg.state == SWP_EXEC)
		&& (st_reg.req.rpmb || (st_reg.req.cmd == `SWP_CMD_GO_IDLE)));

	property p_blocked_switch;
		ex_cmd && (st_reg.req.cmd == `SWP_CMD_SWITCH) && swp_is_wp_index(st_reg.req.addr)
			&& !upd_ok |=> resp.valid && resp.switch_err && $stable(user_wp) && $stable(boot_wp);
	endproperty
	a_blocked_switch: assert property (p_blocked_switch) else $error("switch not blocked");
	property p_permit_path;
		!permit_may_change |=> $stable(st_reg.permit);
	endproperty
	a_permit_path: assert property (p_permit_path) else $error("permit changed");
	property p_info;
		1'b1 |=> protect_capability_info == {6'h00, $past(st_reg.mode[0]), 1'b1};
	endproperty
	a_info: assert property (p_info) else $error("info byte wrong");
	property p_reset_vals;
		$rose(rst_n) |-> (st_reg.mode == 8'h00) && (st_reg.permit == 8'h00);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
	property p_fe_blocked;
		ex_fe && !upd_ok |=> resp.valid && resp.lock_fail && (locked == $past(locked));
	endproperty
	a_fe_blocked: assert property (p_fe_blocked) else $error("erase not refused");
	property p_fe_ok;
		ex_fe && upd_ok && locked && !gt_hard |=> !locked && erase_all && (st_reg.lock_password_length == 4'h0)
			##1 !erase_all;
	endproperty
	a_fe_ok: assert property (p_fe_ok) else $error("erase not done");
	property p_fe_unlocked;
		ex_fe && !locked |=> resp.lock_fail && !erase_all;
	endproperty
	a_fe_unlocked: assert property (p_fe_unlocked) else $error("unlocked erase ran");
	property p_hard_closed;
		|hard_vec |=> (($past(hard_vec) & group_writable) == '0);
	endproperty
	a_hard_closed: assert property (p_hard_closed) else $error("hard group open");
	property p_hw_reprotect;
		!lk.hw_reset_n |=> !st_reg.permit[0] ##1 !perm_active;
	endproperty
	a_hw_reprotect: assert property (p_hw_reprotect) else $error("not re-protected");
	property p_rd_tag;
		(st_reg.state == SWP_EXEC) && st_reg.req.rpmb && (st_reg.req.req_type == `SWP_REQ_CFG_RD)
			|=> resp.valid && (resp.rsp_type == `SWP_RSP_CFG_RD) ##1 !resp.valid;
	endproperty
	a_rd_tag: assert property (p_rd_tag) else $error("bad read tag");
	property p_auth_fail;
		(st_reg.state == SWP_EXEC) && st_reg.req.rpmb && (st_reg.req.req_type == `SWP_REQ_CFG_WR)
			&& !st_reg.req.mac_ok |=> $stable(st_reg.mode) && (resp.result == `SWP_RES_AUTH_FAIL);
	endproperty
	a_auth_fail: assert property (p_auth_fail) else $error("bad frame acted on");

	c_secure_on: cover property (st_reg.permit[0] && st_reg.mode[0]);
	c_erase: cover property (erase_all);
	c_switch_err: cover property (resp.valid && resp.switch_err);
endmodule : swp_ctrl
`default_nettype wire

// file: swp_defines.svh
// Offsets, field positions, reset values and codes for the write-protect control
`ifndef SWP_DEFINES_SVH
`define SWP_DEFINES_SVH
// Hidden configuration area byte addresses
`define SWP_ADC_MODE_ADDR 8'h01
`define SWP_ADC_PERMIT_ADDR 8'h02
// Extended register indexes
`define SWP_USER_WP_INDEX 8'hab
`define SWP_BOOT_WP_INDEX 8'had
`define SWP_BOOT_STAT_INDEX 8'hae
`define SWP_INFO_INDEX 8'hd3
// Reset values
`define SWP_MODE_RESET 8'h00
`define SWP_PERMIT_RESET 8'h00
`define SWP_INFO_RESET 8'h01
// Field positions
`define SWP_EN_BIT 0
`define SWP_INFO_CAP_BIT 0
`define SWP_INFO_EN_BIT 1
`define SWP_UWP_PWR_BIT 0
`define SWP_UWP_PERM_BIT 2
`define SWP_BWP_PWR_BIT 0
`define SWP_BWP_PERM_BIT 2
`define SWP_CSD_TMP_BIT 0
`define SWP_CSD_PERM_BIT 1
`define SWP_LK_LOCK_BIT 2
`define SWP_LK_ERASE_BIT 3
// Command indexes
`define SWP_CMD_GO_IDLE 6'h00
`define SWP_CMD_SWITCH 6'h06
`define SWP_CMD_PROG_CSD 6'h1b
`define SWP_CMD_SET_WP 6'h1c
`define SWP_CMD_CLR_WP 6'h1d
`define SWP_CMD_LOCK 6'h2a
// Replay-protected request and response types
`define SWP_REQ_FIRST 16'h0001
`define SWP_REQ_RESULT 16'h0005
`define SWP_REQ_CFG_WR 16'h0006
`define SWP_REQ_CFG_RD 16'h0007
`define SWP_RSP_CFG_WR 16'h0600
`define SWP_RSP_CFG_RD 16'h0700
// Result codes
`define SWP_RES_OK 8'h00
`define SWP_RES_GEN_FAIL 8'h01
`define SWP_RES_AUTH_FAIL 8'h02
`define SWP_RES_CNT_FAIL 8'h03
`endif

// file: swp_group_table.sv
// Protection type store for the user-area protect groups
`timescale 1ns/1ns
`default_nettype none
module swp_group_table import swp_pkg::*; #(
	parameter int NG = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic set_en,
	input wire logic clr_en,
	input wire logic wipe,
	input wire logic [7:0] idx,
	input wire swp_wp_e set_type,
	output var swp_wp_e [NG-1:0] types,
	output logic hard_any
);
	// One type per group
	typedef struct packed {
		swp_wp_e [NG-1:0] grp;
	} swp_gt_s;
	swp_gt_s st_reg, st_next;
	logic [NG-1:0] hard_w; // Group is power-on or permanent

	// Per-group hard protection flag
	genvar g;
	generate
		for (g = 0; g < NG; g++) begin : g_hard
			assign hard_w[g] = (st_reg.grp[g] == SWP_WP_PWR) || (st_reg.grp[g] == SWP_WP_PERM);
		end
	endgenerate

	// Update one group, or clear all on a forced erase
	always_comb begin
		st_next = st_reg;
		if (wipe) begin
			for (int i = 0; i < NG; i++) begin
				st_next.grp[i] = SWP_WP_NONE;
			end
		end else if (set_en && (idx < NG)) begin
			st_next.grp[idx] = set_type;
		end else if (clr_en && (idx < NG) && (st_reg.grp[idx] == SWP_WP_TEMP)) begin
			// Only temporary protection can be cleared
			st_next.grp[idx] = SWP_WP_NONE;
		end
	end

	// Register the state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign types = st_reg.grp;
	assign hard_any = |hard_w;
endmodule : swp_group_table
`default_nettype wire

// file: swp_host_model.sv
// Host model that sends command frames and pulses the hardware reset pin
`timescale 1ns/1ns
`default_nettype none
module swp_host_model import swp_pkg::*; (
	input wire logic ref_clk,
	output var logic link_clk,
	output var logic link_valid,
	output var swp_frame_s link_frame,
	output var logic hw_reset_n
);
	// Idle pins: link clock parked low, reset released
	initial begin
		link_clk = 1'b0;
		link_valid = 1'b0;
		link_frame = '0;
		hw_reset_n = 1'b1;
	end
	// One frame per call, link clock high for 400 ns, offset from the block clock
	task automatic send(input swp_frame_s f);
		@(posedge ref_clk);
		#37;
		link_frame <= f;
		link_valid <= 1'b1;
		#300 link_clk <= 1'b1;
		// Hold past the rise, then scramble the released bus
		#400 link_clk <= 1'b0;
		link_valid <= 1'b0;
		link_frame <= ~f;
		#400;
	endtask : send
	// Long enough to pass the two-flop synchroniser
	task automatic pulse_reset();
		@(posedge ref_clk);
		hw_reset_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		hw_reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask : pulse_reset
endmodule : swp_host_model
`default_nettype wire

// file: swp_pkg.sv
// Types shared by the write-protect control modules
package swp_pkg;
	// Sequencer states, Gray along idle-exec-respond
	typedef enum logic [1:0] {
		SWP_IDLE = 2'b00,
		SWP_EXEC = 2'b01,
		SWP_RESP = 2'b11
	} swp_state_e;
	// Protection type of one group
	typedef enum logic [1:0] {
		SWP_WP_NONE = 2'b00,
		SWP_WP_TEMP = 2'b01,
		SWP_WP_PWR = 2'b10,
		SWP_WP_PERM = 2'b11
	} swp_wp_e;
	// One command or replay-protected frame from the host
	typedef struct packed {
		logic rpmb;
		logic [5:0] cmd;
		logic [15:0] req_type;
		logic [7:0] addr;
		logic [7:0] data;
		logic mac_ok;
		logic cnt_ok;
		logic [7:0] group;
	} swp_frame_s;
	// Link pins as seen after synchronising
	typedef struct packed {
		logic clk;
		logic valid;
		logic hw_reset_n;
		swp_frame_s frame;
	} swp_link_s;
	// Answer to one frame
	typedef struct packed {
		logic valid;
		logic [15:0] rsp_type;
		logic [7:0] result;
		logic [7:0] data;
		logic generic_err;
		logic switch_err;
		logic lock_fail;
	} swp_resp_s;
endpackage : swp_pkg

// file: swp_sync.sv
// Two-flop synchroniser for pins from the host clock domain
`timescale 1ns/1ns
`default_nettype none
module swp_sync import swp_pkg::*; #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// Metastable stage feeds only the second stage
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} swp_sync_s;
	swp_sync_s st_reg, st_next;

	// Shift one stage per edge
	always_comb begin
		st_next.meta = d;
		st_next.sync = st_reg.meta;
	end

	// Register the state
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.sync;
endmodule : swp_sync
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the secure write-protect control
`timescale 1ns/1ns
`default_nettype none
module testbench import swp_pkg::*; ;
	localparam int NG = 8;
	logic ref_clk;
	logic rst_n;
	logic link_clk, link_valid, hw_reset_n;
	swp_frame_s link_frame;
	swp_resp_s resp;
	logic [7:0] info, user_wp, boot_wp;
	logic [1:0] csd_wp;
	logic [NG-1:0] group_writable;
	logic boot_writable, locked, erase_all;
	// Reference state predicted by the bench
	logic [7:0] m_mode, m_permit, m_uwp, m_bwp, m_last;
	logic [1:0] m_csd;
	logic m_lock;
	swp_wp_e m_g [NG];
	// Notes hold {mask, expected}
	logic [125:0] notes [$];
	int num_errors, compares, seed;
	// Free-running 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	swp_ctrl #(.NG(NG)) i_swp_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
		.link_valid(link_valid), .link_frame(link_frame), .hw_reset_n(hw_reset_n),
		.resp(resp), .protect_capability_info(info), .user_wp(user_wp), .boot_wp(boot_wp),
		.csd_wp(csd_wp), .group_writable(group_writable), .boot_writable(boot_writable),
		.locked(locked), .erase_all(erase_all));
	swp_host_model i_swp_host_model (.ref_clk(ref_clk), .link_clk(link_clk),
		.link_valid(link_valid), .link_frame(link_frame), .hw_reset_n(hw_reset_n));
	task automatic check(input logic [62:0] seen, input logic [62:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("Compares %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	// Power-up values of the reference state
	task automatic do_reset(input int n);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (n) @(posedge ref_clk);
		rst_n <= 1'b1;
		{m_mode, m_permit, m_uwp, m_bwp, m_last, m_csd, m_lock} = '0;
		for (int i = 0; i < NG; i++) m_g[i] = SWP_WP_NONE;
		repeat (2) @(posedge ref_clk);
	endtask : do_reset
	// Writable flags settle a cycle after the answer, so look before the next frame
	task automatic check_writable();
		logic [NG-1:0] gw;
		logic open;
		logic bw;
		open = m_mode[0] & m_permit[0];
		for (int i = 0; i < NG; i++) gw[i] = m_g[i] == SWP_WP_NONE || (m_g[i] == SWP_WP_TEMP && open);
		bw = !(m_bwp[0] | m_bwp[2]) || (open && !m_bwp[2]);
		check({54'h0, boot_writable, group_writable}, {54'h0, bw, gw});
	endtask : check_writable
	// Predicts one frame, notes the answer, then sends it
	task automatic op(input logic rp, input logic [5:0] c, input logic [15:0] t,
		input logic [7:0] a, input logic [7:0] d, input logic mac, input logic cnt,
		input logic [7:0] g);
		logic [15:0] rt;
		logic [7:0] rs, rd;
		logic [3:0] fl;
		logic ok, hard, om;
		logic [62:0] mk;
		repeat (2) @(posedge ref_clk);
		check_writable();
		rt = 16'h0000;
		rs = 8'h00;
		rd = 8'h00;
		fl = 4'h0;
		// Command tags are unspecified, so only flags and state are compared
		mk = rp ? {{24{1'b1}}, 8'h00, {31{1'b1}}} : {32'h0, {31{1'b1}}};
		ok = !m_mode[0] | m_permit[0];
		hard = 1'b0;
		// Info byte shows a mode write one cycle after the answer
		om = m_mode[0];
		for (int i = 0; i < NG; i++) hard |= m_g[i] inside {SWP_WP_PWR, SWP_WP_PERM};
		if (rp) begin
			case (t)
				16'h0006: begin
					rt = 16'h0600;
					if (!mac) rs = 8'h02;
					else if (!cnt) rs = 8'h03;
					else if (a == 8'h01) m_mode = {7'h00, d[0]};
					else if (a == 8'h02) m_permit = {7'h00, d[0]};
					m_last = rs;
				end
				16'h0007: begin
					rt = 16'h0700;
					rd = (a == 8'h01) ? m_mode : (a == 8'h02) ? m_permit : 8'h00;
					mk = '1;
				end
				16'h0005: begin
					rt = 16'h0600;
					rs = m_last;
				end
				default: begin
					rt = {t[7:0], 8'h00};
					// Types outside the defined range get a generic failure
					if (t < 16'h0001 || t > 16'h0007) rs = 8'h01;
				end
			endcase
		end else begin
			case (c)
				6'h00: m_permit = 8'h00;
				6'h06: begin
					if (a inside {8'hab, 8'had, 8'hae} && !ok) fl[2] = 1'b1;
					else if (a == 8'hab) m_uwp = d;
					else if (a == 8'had) m_bwp = d;
				end
				6'h1b, 6'h1c, 6'h1d: begin
					if (!ok) fl[3] = 1'b1;
					else if (c == 6'h1b) m_csd = d[1:0];
					else if (c == 6'h1c) m_g[g[2:0]] = m_uwp[2] ? SWP_WP_PERM :
						m_uwp[0] ? SWP_WP_PWR : SWP_WP_TEMP;
					else if (m_g[g[2:0]] == SWP_WP_TEMP) m_g[g[2:0]] = SWP_WP_NONE;
				end
				6'h2a: begin
					if (!d[3]) m_lock = d[2];
					else if (!ok || !m_lock || hard) fl[1] = 1'b1;
					else begin
						m_lock = 1'b0;
						fl[0] = 1'b1;
						for (int i = 0; i < NG; i++) m_g[i] = SWP_WP_NONE;
					end
				end
				default: ;
			endcase
		end
		notes.push_back({mk, rt, rs, rd, fl, 6'h00, om, 1'b1, m_uwp, m_bwp, m_csd, m_lock});
		i_swp_host_model.send({rp, c, t, a, d, mac, cnt, g});
	endtask : op
	task automatic cfg(input logic [15:0] t, input logic [7:0] a, input logic [7:0] d,
		input logic mac, input logic cnt);
		op(1'b1, 6'h00, t, a, d, mac, cnt, 8'h00);
	endtask : cfg
	task automatic cmd(input logic [5:0] c, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] g);
		op(1'b0, c, 16'h0000, a, d, 1'b1, 1'b1, g);
	endtask : cmd
	// Each answer is matched against the oldest note
	always @(negedge ref_clk) begin
		logic [125:0] n;
		logic [62:0] s;
		if (rst_n === 1'b1 && resp.valid === 1'b1) begin
			s = {resp.rsp_type, resp.result, resp.data, resp.generic_err, resp.switch_err,
				resp.lock_fail, erase_all, info, user_wp, boot_wp, csd_wp, locked};
			if (notes.size() == 0) begin
				// An answer that nobody asked for always counts
				check(63'h1, 63'h0);
			end else begin
				n = notes.pop_front();
				check(s & n[125:63], n[62:0] & n[125:63]);
			end
		end
	end
	// Main sequence
	initial begin
		seed = 46;
		num_errors = 0;
		compares = 0;
		rst_n = 1'b0;
		do_reset(6);
		for (int a = 0; a < 4; a++) cfg(16'h0007, a[7:0], 8'h00, 1'b1, 1'b1);
		for (int t = 0; t < 5; t++) cfg(t[15:0], 8'h00, 8'h00, 1'b1, 1'b1);
		cfg(16'h0008, 8'h00, 8'h00, 1'b1, 1'b1);
		// Legacy mode: plain commands set protection
		cmd(6'h06, 8'hab, 8'($random(seed)), 8'h00);
		cmd(6'h1b, 8'h00, 8'($random(seed)), 8'h00);
		cmd(6'h06, 8'hab, 8'h01, 8'h00);
		cmd(6'h1c, 8'h00, 8'h00, 8'h01);
		cmd(6'h06, 8'hab, 8'h00, 8'h00);
		cmd(6'h1c, 8'h00, 8'h00, 8'h02);
		cmd(6'h1c, 8'h00, 8'h00, 8'h03);
		cmd(6'h06, 8'had, 8'h01, 8'h00);
		cmd(6'h2a, 8'h04, 8'h04, 8'h00);
		// Failed checks leave the mode alone
		cfg(16'h0006, 8'h01, 8'h01, 1'b0, 1'b1);
		cfg(16'h0006, 8'h01, 8'h01, 1'b1, 1'b0);
		cfg(16'h0005, 8'h00, 8'h00, 1'b1, 1'b1);
		cfg(16'h0006, 8'h01, 8'h01, 1'b1, 1'b1);
		// Secure mode with updates blocked
		cmd(6'h06, 8'hab, 8'h04, 8'h00);
		cmd(6'h06, 8'had, 8'h04, 8'h00);
		cmd(6'h06, 8'hae, 8'h01, 8'h00);
		cmd(6'h1b, 8'h00, 8'h01, 8'h00);
		cmd(6'h1c, 8'h00, 8'h00, 8'h04);
		cmd(6'h1d, 8'h00, 8'h00, 8'h02);
		cmd(6'h2a, 8'h00, 8'h08, 8'h00);
		cmd(6'h00, 8'h00, 8'h00, 8'h00);
		i_swp_host_model.pulse_reset();
		// Permit opens temporary and boot power-on areas only
		cfg(16'h0006, 8'h02, 8'h01, 1'b1, 1'b1);
		cmd(6'h06, 8'hab, 8'h04, 8'h00);
		cmd(6'h1c, 8'h00, 8'h00, 8'h05);
		cmd(6'h1d, 8'h00, 8'h00, 8'h02);
		cmd(6'h1d, 8'h00, 8'h00, 8'h01);
		cmd(6'h2a, 8'h00, 8'h08, 8'h00);
		i_swp_host_model.pulse_reset();
		m_permit = 8'h00;
		cfg(16'h0007, 8'h02, 8'h00, 1'b1, 1'b1);
		cfg(16'h0006, 8'h02, 8'h01, 1'b1, 1'b1);
		cmd(6'h00, 8'h00, 8'h00, 8'h00);
		cfg(16'h0007, 8'h02, 8'h00, 1'b1, 1'b1);
		// Fresh power-up, then a forced erase that succeeds
		do_reset(3);
		cfg(16'h0006, 8'h01, 8'h01, 1'b1, 1'b1);
		cfg(16'h0006, 8'h02, 8'h01, 1'b1, 1'b1);
		cmd(6'h2a, 8'h04, 8'h04, 8'h00);
		cmd(6'h2a, 8'h00, 8'h08, 8'h00);
		cmd(6'h2a, 8'h00, 8'h08, 8'h00);
		for (int i = 0; i < 100 && notes.size() > 0; i++) @(posedge ref_clk);
		if (notes.size() != 0) check(63'h1, 63'h0);
		check_writable();
		give_verdict();
	end
	// Watchdog far beyond the expected run length
	initial begin
		#400000;
		num_errors++;
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
